/* File: sic_err_latch.sv */
module sic_err_latch (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick_i,
  input  wire logic        event_i,
  input  wire logic [15:0] hold_ticks_i,
  output logic             active_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        act;
  } sic_lat_st_t;

  sic_lat_st_t q;
  sic_lat_st_t n;

  always_comb begin
    n = q;
    if (event_i) begin
      // a new error restarts the hold from the full time
      n.cnt = hold_ticks_i;  // see [R11]
      n.act = 1'b1;
    end else if (q.act && tick_i) begin
      // release on the tick after the count runs out, so the hold never
      // falls short of the full time whatever the tick phase
      if (q.cnt == 16'h0000) begin
        n.act = 1'b0;  // see [R11]
      end else begin
        n.cnt = q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign active_o = q.act;

endmodule // sic_err_latch

/* File: sic_field.sv */
module sic_field (
  input  wire logic [7:0] test_out,
  input  wire logic [7:0] closed,
  input  wire logic [7:0] stuck,
  input  wire logic [7:0] pulsed,
  output logic      [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // a pulsed switch draws its supply from the test output of its own index;
  // a short to supply wins over everything
  assign pin = stuck | (closed & (~pulsed | test_out));
endmodule // sic_field

/* File: sic_pkg.sv */
package sic_pkg;

  localparam int NPT   = 8;
  localparam int NPAIR = 4;
  localparam int NTEST = 8;

  // time base: one tick of TICK_US, all delays but the sync guard counted in ticks
  localparam int CLK_MHZ     = 250;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TICKS_PER_MS = 1000 / TICK_US;

  localparam int FILT_STEP_MS  = 6;
  localparam int FILT_MAX_MS   = 126;
  localparam int LATCH_STEP_MS = 10;
  localparam int LATCH_DEF_MS  = 1000;
  localparam int DISC_STEP_MS  = 10;

  localparam logic [6:0]  FILT_STEP_TICKS  = 7'(FILT_STEP_MS * TICKS_PER_MS);
  localparam logic [4:0]  FILT_MAX_STEPS   = 5'(FILT_MAX_MS / FILT_STEP_MS);
  localparam logic [15:0] LATCH_STEP_TICKS = 16'(LATCH_STEP_MS * TICKS_PER_MS);
  localparam logic [11:0] DISC_STEP_TICKS  = 12'(DISC_STEP_MS * TICKS_PER_MS);
  localparam logic [12:0] LATCH_RST        = 13'(LATCH_DEF_MS / LATCH_STEP_MS);

  // cycles after a test pulse ends in which the input is still recovering
  localparam logic [17:0] SYNC_GUARD_CYCLES = 18'h00008;

  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [2:0] OFS_PCFG_PAGE = 3'h1;  // 0x20..0x3C, one per point
  localparam logic [3:0] OFS_PAIR_PAGE = 4'h4;  // 0x40..0x4C, one per pair

  // point configuration fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SRC_LSB  = 2;
  localparam int CFG_ON_LSB   = 6;
  localparam int CFG_OFF_LSB  = 11;
  localparam int CFG_W        = 16;
  // pair configuration fields
  localparam int PR_OP_LSB   = 0;
  localparam int PR_DISC_LSB = 4;
  localparam int PR_W        = 12;
  // status layout: point events low, pair events above
  localparam int STAT_PAIR_LSB = 8;
  localparam int STAT_W        = 12;

  localparam logic [CFG_W-1:0]  CFG_RST  = 16'h0000;
  localparam logic [PR_W-1:0]   PAIR_RST = 12'h000;
  localparam logic [STAT_W-1:0] MASK_RST = 12'h000;

  typedef enum logic [1:0] {
    SIC_UNUSED = 2'h0,
    SIC_PULSE  = 2'h1,
    SIC_SAFETY = 2'h2,
    SIC_STD    = 2'h3
  } sic_mode_t;

  typedef enum logic [1:0] {
    SIC_SINGLE = 2'h0,
    SIC_EQUIV  = 2'h1,
    SIC_COMPL  = 2'h2
  } sic_op_t;

  typedef enum logic [2:0] {
    DISC_IDLE = 3'h1,
    DISC_RUN  = 3'h2,
    DISC_FLT  = 3'h4
  } sic_disc_t;

endpackage

/* File: sic_top.sv */
// Summary of operation
// [R1] a point whose pair is set to single is judged alone, with no cross-check.
// [R2] an equivalent pair faults if both filtered values are not equal in time.
// [R3] a complementary pair faults if the values are not opposite in time.
// [R4] an unused point always reports 0, whatever its terminal does.
// [R5] a pulse-tested point faults if it stays high through its source pulse.
// [R6] a safety-mode point is accepted without any pulse check.
// [R7] a standard-mode point inside a dual-channel pair is a configuration fault.
// [R8] each point selects no test source or test output 0 upward by number.
// [R9] the value goes to 1 only after the input was high for the on delay.
// [R10] the value goes to 0 only after the input was low for the off delay.
// [R11] every detected error is held for the programmed latch time; above 6553 steps the code wraps the hold ticks at 16 bits.
// [R12] the pair timer starts on the first change and faults on expiry.
module sic_top #(
  parameter int TICK_CYCLES = sic_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  pin_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic      [7:0]  data_o,
  output logic      [7:0]  test_out_o,
  output logic      [7:0]  point_err_o,
  output logic      [3:0]  pair_err_o,
  output logic             irq_o
);

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [7:0]                         s1;
    logic [7:0]                         s2;
    logic [7:0]                         s3;
    logic [7:0]                         stab;
    logic [7:0]                         filt;
    logic [7:0]                         data;
    logic [7:0]                         tout;
    logic [7:0][6:0]                    fcnt;
    logic [7:0][sic_pkg::CFG_W-1:0]     cfg;
    logic [3:0][sic_pkg::PR_W-1:0]      pcfg;
    sic_pkg::sic_disc_t [3:0]           dst;
    logic [3:0][11:0]                   dcnt;
    logic [12:0]                        latch;
    logic [sic_pkg::STAT_W-1:0]         mask;
    logic [sic_pkg::STAT_W-1:0]         stat;
    logic [31:0]                        rdata;
    logic [17:0]                        tcnt;
    logic [3:0]                         pcnt;
    logic                               tick;
    logic                               irq;
  } sic_top_st_t;

  sic_top_st_t q;
  sic_top_st_t n;

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        rst_int_n;
  logic [7:0]  pt_ev;
  logic [3:0]  pr_ev;
  logic [7:0]  pt_act;
  logic [3:0]  pr_act;
  logic [15:0] latch_ticks;

  // reset is released through two flops; everything else uses the copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_int_n = rst_s2_q;

  assign latch_ticks = 16'({3'h0, q.latch} * sic_pkg::LATCH_STEP_TICKS);

  genvar gi;
  generate
    for (gi = 0; gi < sic_pkg::NPT; gi++) begin : g_pt_latch
      sic_err_latch u_lat (
        .clk          (clk),
        .rst_n        (rst_int_n),
        .tick_i       (q.tick),
        .event_i      (pt_ev[gi]),
        .hold_ticks_i (latch_ticks),
        .active_o     (pt_act[gi])
      );
    end
    for (gi = 0; gi < sic_pkg::NPAIR; gi++) begin : g_pr_latch
      sic_err_latch u_lat (
        .clk          (clk),
        .rst_n        (rst_int_n),
        .tick_i       (q.tick),
        .event_i      (pr_ev[gi]),
        .hold_ticks_i (latch_ticks),
        .active_o     (pr_act[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [7:0]  pulse_end;
    logic [7:0]  hold;
    logic [3:0]  prev_pcnt;
    logic [3:0]  src;
    logic [2:0]  sidx;
    logic        src_ok;
    logic [1:0]  mode;
    logic [4:0]  steps;
    logic [6:0]  target;
    logic [7:0]  paired_pt;
    logic [1:0]  op;
    logic        paired;
    logic        a;
    logic        b;
    logic        rel_ok;
    logic [11:0] lim;
    logic        rd_stat;
    logic [2:0]  pidx;
    logic [1:0]  ridx;
    n         = q;
    pulse_end = 8'h00;
    hold      = 8'h00;
    prev_pcnt = q.pcnt - 4'h1;
    src       = 4'h0;
    sidx      = 3'h0;
    src_ok    = 1'b0;
    mode      = 2'h0;
    steps     = 5'h00;
    target    = 7'h00;
    paired_pt = 8'h00;
    op        = 2'h0;
    paired    = 1'b0;
    a         = 1'b0;
    b         = 1'b0;
    rel_ok    = 1'b1;
    lim       = 12'h000;
    pt_ev     = 8'h00;
    pr_ev     = 4'h0;
    rd_stat   = rd_i && (addr_i == sic_pkg::OFS_STAT);
    pidx      = addr_i[4:2];
    ridx      = addr_i[3:2];

    // three-flop input sampling; a level counts once stages two and three agree
    n.s1 = pin_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < sic_pkg::NPT; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.stab[i] = q.s3[i];
      end
    end

    // time base
    n.tick = (q.tcnt == TICK_LAST);
    n.tcnt = n.tick ? 18'h00000 : q.tcnt + 18'h00001;

    // test pulses: outputs take turns, one tick low each, in a 16-tick round
    if (q.tick) begin
      n.pcnt = q.pcnt + 4'h1;  // see [R5]
    end
    for (int k = 0; k < sic_pkg::NTEST; k++) begin
      n.tout[k] = !(n.pcnt[0] && (n.pcnt[3:1] == 3'(k)));
      pulse_end[k] = q.tick && q.pcnt[0] && (q.pcnt[3:1] == 3'(k));
      // the guard covers the input synchroniser catching up after the pulse
      hold[k] = (q.pcnt[0] && (q.pcnt[3:1] == 3'(k)))
             || (!q.pcnt[0] && (prev_pcnt[3:1] == 3'(k))
                 && (q.tcnt < sic_pkg::SYNC_GUARD_CYCLES));
    end

    // which points belong to a dual-channel pair
    for (int p = 0; p < sic_pkg::NPAIR; p++) begin
      op = q.pcfg[p][sic_pkg::PR_OP_LSB +: 2];
      paired = (op == sic_pkg::SIC_EQUIV) || (op == sic_pkg::SIC_COMPL);
      paired_pt[2*p]   = paired;
      paired_pt[2*p+1] = paired;
    end

    // per point: filter, pulse check, configuration check
    for (int i = 0; i < sic_pkg::NPT; i++) begin
      mode = q.cfg[i][sic_pkg::CFG_MODE_LSB +: 2];
      src  = q.cfg[i][sic_pkg::CFG_SRC_LSB +: 4];
      // code 0 is no source, code k is test output k-1
      src_ok = (src != 4'h0) && (src <= 4'(sic_pkg::NTEST));  // see [R8]
      sidx = 3'(src - 4'h1);
      if (q.stab[i] == q.filt[i]) begin
        n.fcnt[i] = 7'h00;
      end else if (mode == sic_pkg::SIC_PULSE && src_ok && hold[sidx]) begin
        // input is expected low during its own pulse: freeze the filter
        n.fcnt[i] = q.fcnt[i];
      end else begin
        if (q.stab[i]) begin
          steps = q.cfg[i][sic_pkg::CFG_ON_LSB +: 5];  // see [R9]
        end else begin
          steps = q.cfg[i][sic_pkg::CFG_OFF_LSB +: 5];  // see [R10]
        end
        if (steps > sic_pkg::FILT_MAX_STEPS) begin
          steps = sic_pkg::FILT_MAX_STEPS;
        end
        target = 7'({2'h0, steps} * sic_pkg::FILT_STEP_TICKS);
        // the first tick may come at once, so wait one tick past the target:
        // only then has the input stood for the whole delay
        if ((target == 7'h00) || (q.fcnt[i] > target)) begin
          n.filt[i] = q.stab[i];  // see [R9] [R10]
          n.fcnt[i] = 7'h00;
        end else if (q.tick) begin
          n.fcnt[i] = q.fcnt[i] + 7'h01;
        end
      end
      // only a pulse-tested point is checked; safety mode trusts the device
      if (mode == sic_pkg::SIC_PULSE) begin  // see [R6]
        if (!src_ok) begin
          pt_ev[i] = 1'b1;  // see [R8]
        end else if (pulse_end[sidx] && q.stab[i]) begin
          // high through its pulse: short to supply or to another channel
          pt_ev[i] = 1'b1;  // see [R5]
        end
      end
      if (paired_pt[i] && mode == sic_pkg::SIC_STD) begin
        pt_ev[i] = 1'b1;  // see [R7]
      end
      // unused points and points in error never report 1
      n.data[i] = q.filt[i] && (mode != sic_pkg::SIC_UNUSED)  // see [R4]
               && !pt_act[i]
               && !(paired_pt[i] && pr_act[i/2]);  // see [R1]
    end

    // discrepancy timing per pair
    for (int p = 0; p < sic_pkg::NPAIR; p++) begin
      op = q.pcfg[p][sic_pkg::PR_OP_LSB +: 2];
      paired = (op == sic_pkg::SIC_EQUIV) || (op == sic_pkg::SIC_COMPL);
      a = q.filt[2*p];
      b = q.filt[2*p+1];
      if (op == sic_pkg::SIC_EQUIV) begin
        rel_ok = (a == b);  // see [R2]
      end else begin
        rel_ok = (a != b);  // see [R3]
      end
      lim = 12'(q.pcfg[p][sic_pkg::PR_DISC_LSB +: 8]
            * sic_pkg::DISC_STEP_TICKS);
      case (q.dst[p])
        sic_pkg::DISC_IDLE: begin
          // first channel changed, the other has not followed yet
          if (paired && !rel_ok) begin  // see [R12]
            n.dcnt[p] = 12'h000;
            if (lim == 12'h000) begin
              n.dst[p] = sic_pkg::DISC_FLT;
              pr_ev[p] = 1'b1;
            end else begin
              n.dst[p] = sic_pkg::DISC_RUN;
            end
          end
        end
        sic_pkg::DISC_RUN: begin
          if (!paired || rel_ok) begin
            n.dst[p] = sic_pkg::DISC_IDLE;  // see [R12]
          end else if (q.tick) begin
            // one tick of slack so a fault never comes before the full time
            if (q.dcnt[p] >= lim) begin
              n.dst[p] = sic_pkg::DISC_FLT;
              pr_ev[p] = 1'b1;  // see [R2] [R3] [R12]
            end else begin
              n.dcnt[p] = q.dcnt[p] + 12'h001;
            end
          end
        end
        sic_pkg::DISC_FLT: begin
          // the fault holds on in the latch; the timer rearms once settled
          if (!paired || rel_ok) begin
            n.dst[p] = sic_pkg::DISC_IDLE;
          end
        end
        default: begin
          n.dst[p] = sic_pkg::DISC_IDLE;
        end
      endcase
    end

    // register writes
    if (wr_i) begin
      if (addr_i == sic_pkg::OFS_CTRL) begin
        n.latch = wdata_i[12:0];
      end else if (addr_i == sic_pkg::OFS_MASK) begin
        n.mask = wdata_i[sic_pkg::STAT_W-1:0];
      end else if (addr_i[7:5] == sic_pkg::OFS_PCFG_PAGE) begin
        n.cfg[pidx] = wdata_i[sic_pkg::CFG_W-1:0];
      end else if (addr_i[7:4] == sic_pkg::OFS_PAIR_PAGE) begin
        n.pcfg[ridx] = wdata_i[sic_pkg::PR_W-1:0];
      end
    end

    // sticky status: a read clears, an event in the same cycle still lands
    n.stat = (rd_stat ? '0 : q.stat)
           | {pr_ev, pt_ev};
    n.irq  = |(n.stat & n.mask);

    // read data stand for exactly one cycle after the strobe
    n.rdata = 32'h00000000;
    if (rd_i) begin
      if (addr_i == sic_pkg::OFS_CTRL) begin
        n.rdata = {19'h00000, q.latch};
      end else if (addr_i == sic_pkg::OFS_STAT) begin
        n.rdata = {20'h00000, q.stat};
      end else if (addr_i == sic_pkg::OFS_MASK) begin
        n.rdata = {20'h00000, q.mask};
      end else if (addr_i == sic_pkg::OFS_DATA) begin
        n.rdata = {12'h000, pr_act, pt_act, q.data};
      end else if (addr_i[7:5] == sic_pkg::OFS_PCFG_PAGE) begin
        n.rdata = {16'h0000, q.cfg[pidx]};
      end else if (addr_i[7:4] == sic_pkg::OFS_PAIR_PAGE) begin
        n.rdata = {20'h00000, q.pcfg[ridx]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      q       <= '0;
      q.tout  <= 8'hFF;
      q.cfg   <= {8{sic_pkg::CFG_RST}};
      q.pcfg  <= {4{sic_pkg::PAIR_RST}};
      q.dst   <= {4{sic_pkg::DISC_IDLE}};
      q.latch <= sic_pkg::LATCH_RST;
      q.mask  <= sic_pkg::MASK_RST;
    end else begin
      q <= n;
    end
  end

  assign rdata_o     = q.rdata;
  assign data_o      = q.data;
  assign test_out_o  = q.tout;
  assign point_err_o = pt_act;
  assign pair_err_o  = pr_act;
  assign irq_o       = q.irq;

endmodule // sic_top

/* File: sic_top_asserts.sv */
module sic_top_chk #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  pin_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [7:0]  data_o,
  input wire logic [7:0]  test_out_o,
  input wire logic [7:0]  point_err_o,
  input wire logic [3:0]  pair_err_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0]  h_q [8];
  logic [17:0] low_q;
  logic [7:0]  hi_seen;
  logic [7:0]  lo_seen;
  logic [7:0]  pe8;
  logic [7:0]  err8;
  // eight cycles of pin history cover the sampler plus a zero filter delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 8; k++) h_q[k] <= 8'h00;
      low_q <= 18'h00000;
    end else begin
      h_q[0] <= pin_i;
      for (int k = 1; k < 8; k++) h_q[k] <= h_q[k-1];
      low_q <= test_out_o[0] ? 18'h00000 : low_q + 18'h00001;
    end
  end
  always_comb begin
    hi_seen = 8'h00;
    lo_seen = 8'h00;
    for (int k = 0; k < 8; k++) begin
      hi_seen = hi_seen | h_q[k];
      lo_seen = lo_seen | ~h_q[k];
    end
    for (int p = 0; p < 4; p++) begin
      pe8[2*p]   = pair_err_o[p];
      pe8[2*p+1] = pair_err_o[p];
    end
    err8 = point_err_o | pe8;
  end
  sequence s_no_read;
    !rd_i ##1 1'b1;
  endsequence
  sequence s_rd_data;
    rd_i && addr_i == 8'h0C ##1 1'b1;
  endsequence
  chk_rdata_idle: assert property (s_no_read |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  chk_data_mirror: assert property (s_rd_data |->
    rdata_o[15:0] == {$past(point_err_o), $past(data_o)})
    else $error("data register differs from outputs");
  chk_err_blocks: assert property (
    (point_err_o & $past(point_err_o) & data_o) == 8'h00)
    else $error("value high under point error");
  chk_pair_blocks: assert property (
    (pe8 & $past(pe8) & data_o) == 8'h00)
    else $error("value high under pair fault");
  chk_rise_high: assert property (
    (data_o & ~$past(data_o) & ~hi_seen & ~$past(err8)) == 8'h00)
    else $error("value rose without a high input");
  chk_fall_low: assert property (
    (~data_o & $past(data_o) & ~lo_seen & ~err8 & ~$past(err8)) == 8'h00)
    else $error("value fell without a low input");
  chk_pulse_width: assert property (
    $rose(test_out_o[0]) |-> low_q == 18'(TICK_CYCLES))
    else $error("test pulse width wrong");
  chk_one_pulse: assert property ($onehot0(~test_out_o))
    else $error("two test outputs low at once");
endmodule // sic_top_chk

bind sic_top sic_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .pin_i(pin_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .data_o(data_o), .test_out_o(test_out_o), .point_err_o(point_err_o),
  .pair_err_o(pair_err_o), .irq_o(irq_o));

/* File: sic_top_tb.sv */
module sic_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          TC  = 20;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic [7:0]  data_o;
  logic [7:0]  test_out_o;
  logic [7:0]  point_err_o;
  logic [3:0]  pair_err_o;
  logic        irq_o;
  logic [7:0]  pin_i;
  logic [7:0]  closed;
  logic [7:0]  stuck;
  logic [7:0]  pulsed;
  int          failures = 0;
  int          checks = 0;
  int          cycles = 0;

  sic_top #(.TICK_CYCLES(TC)) uut (.clk(clk), .rst_n(rst_n), .pin_i(pin_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .data_o(data_o), .test_out_o(test_out_o),
    .point_err_o(point_err_o), .pair_err_o(pair_err_o), .irq_o(irq_o));
  sic_field field (.test_out(test_out_o), .closed(closed), .stuck(stuck),
    .pulsed(pulsed), .pin(pin_i));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang costs one mismatch, then the normal closing report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      failures++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge clk);
    wr_i    <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge clk);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge clk);
    rd_i   <= 1'h0;
    #1;
    chk(n, rdata_o & m, e);
  endtask
  task automatic setp(input int i, input logic c);
    @(posedge clk);
    closed[i] <= c;
  endtask

  initial begin
    rst_n = 1'h0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'h0;
    rd_i = 1'h0;
    closed = 8'h00;
    stuck = 8'h00;
    pulsed = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    cyc(4);
    rc("ctrl", 8'h00, 32'h64, ALL);
    rc("mask", 8'h08, 32'h0, ALL);
    rc("pcfg", 8'h20, 32'h0, ALL);
    rc("pair", 8'h40, 32'h0, ALL);
    rc("stat", 8'h04, 32'h0, ALL);
    wr(8'hFC, ALL);
    rc("hole", 8'hFC, 32'h0, ALL);
    wr(8'h00, 32'h2);
    rc("ctrl", 8'h00, 32'h2, ALL);
    $display("test registers done");
    setp(0, 1'h1);
    cyc(100);
    chk("d0", data_o[0], 1'h0);
    rc("data", 8'h0C, 32'h0, 32'hFF);
    $display("test unused done");
    // on delay one step, off delay two; the tick phase adds up to one tick
    wr(8'h24, 32'h1042);
    setp(1, 1'h1);
    cyc(90);
    chk("d1", data_o[1], 1'h0);
    cyc(60);
    chk("d1", data_o[1], 1'h1);
    setp(1, 1'h0);
    cyc(205);
    chk("d1", data_o[1], 1'h1);
    cyc(70);
    chk("d1", data_o[1], 1'h0);
    $display("test filter done");
    wr(8'h28, 32'h0D);
    wr(8'h08, 32'h004);
    @(posedge clk);
    pulsed[2] <= 1'h1;
    closed[2] <= 1'h1;
    cyc(400);
    chk("d2", data_o[2], 1'h1);
    chk("e2", point_err_o[2], 1'h0);
    @(posedge clk);
    stuck[2] <= 1'h1;
    cyc(400);
    chk("e2", point_err_o[2], 1'h1);
    chk("d2", data_o[2], 1'h0);
    chk("irq", irq_o, 1'h1);
    // let the sampler drop the short before the clearing read, so no late
    // pulse event can land after it
    @(posedge clk);
    stuck[2] <= 1'h0;
    cyc(8);
    rc("stat", 8'h04, 32'h4, 32'h4);
    cyc(500);
    chk("e2", point_err_o[2], 1'h0);
    rc("stat", 8'h04, 32'h0, 32'h4);
    rc("stat", 8'h04, 32'h0, 32'h4);
    cyc(2);
    chk("irq", irq_o, 1'h0);
    wr(8'h2C, 32'h1);
    cyc(10);
    chk("e3", point_err_o[3], 1'h1);
    chk("irq", irq_o, 1'h0);
    wr(8'h2C, 32'h0);
    $display("test pulse done");
    setp(0, 1'h0);
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h2);
    wr(8'h08, 32'h100);
    wr(8'h40, 32'h11);
    cyc(20);
    setp(0, 1'h1);
    cyc(170);
    chk("p0", pair_err_o[0], 1'h0);
    cyc(80);
    chk("p0", pair_err_o[0], 1'h1);
    chk("irq", irq_o, 1'h1);
    setp(1, 1'h1);
    cyc(300);
    chk("p0", pair_err_o[0], 1'h1);
    cyc(140);
    chk("p0", pair_err_o[0], 1'h0);
    rc("stat", 8'h04, 32'h100, 32'h100);
    cyc(3);
    chk("irq", irq_o, 1'h0);
    wr(8'h30, 32'h2);
    wr(8'h34, 32'h2);
    wr(8'h48, 32'h12);
    setp(4, 1'h1);
    cyc(300);
    chk("p2", pair_err_o[2], 1'h0);
    setp(5, 1'h1);
    cyc(250);
    chk("p2", pair_err_o[2], 1'h1);
    wr(8'h38, 32'h2);
    wr(8'h3C, 32'h2);
    setp(6, 1'h1);
    cyc(300);
    chk("p3", pair_err_o[3], 1'h0);
    chk("d6", data_o[6], 1'h1);
    wr(8'h38, 32'h3);
    wr(8'h4C, 32'h1);
    cyc(10);
    chk("e6", point_err_o[6], 1'h1);
    $display("test pairs done");
    conclude();
  end
endmodule // sic_top_tb
